// File: rtl/nvt_pkg.sv
// Purpose: Constants shared by the trim and drive setting control block
// Assumes: Command bytes arrive already framed by the host bus front end
// Notes: Line rate divisors are plain defaults, not measured figures
package nvt_pkg;
  // ****************************************
  // Command opcodes
  // ****************************************
  localparam logic [7:0] OP_TRIM_CTRL = 8'hB8;
  localparam logic [7:0] OP_TRIM_MASK = 8'hB9;
  localparam logic [7:0] OP_POT_LOW = 8'hF4;
  localparam logic [7:0] OP_POT_HIGH = 8'hF5;
  localparam logic [7:0] OP_WR_TIMER = 8'hF6;
  localparam logic [7:0] OP_RD_TIMER = 8'hF7;
  localparam logic [7:0] OP_BIAS_MASK = 8'hFC;
  localparam logic [7:0] OP_BIAS_VAL = 8'hE8;
  localparam logic [7:0] OP_TC_MASK = 8'hFC;
  localparam logic [7:0] OP_TC_VAL = 8'h1C;
  localparam logic [7:0] OP_PWR_MASK = 8'hF0;
  localparam logic [7:0] OP_PWR_VAL = 8'h20;
  localparam logic [7:0] OP_DRV_MASK = 8'hFE;
  localparam logic [7:0] OP_DRV_VAL = 8'hAE;
  localparam logic [7:0] OP_LC_MASK = 8'hF0;
  localparam logic [7:0] OP_LC_VAL = 8'hD0;
  localparam logic [7:0] OP_COM_END = 8'hF1;
  localparam logic [7:0] OP_PART_START = 8'hF2;
  localparam logic [7:0] OP_PART_END = 8'hF3;
  localparam logic [7:0] OP_FIX_TOP = 8'h90;
  localparam logic [7:0] OP_FIX_BOT = 8'h91;
  // ****************************************
  // Trim control fields
  // ****************************************
  localparam int TC_CMD_LSB = 0;
  localparam int TC_EN_BIT = 3;
  localparam int TC_VALID_BIT = 4;
  localparam int TC_TEST_BIT = 5;
  localparam logic [5:0] TRIM_CTRL_RST = 6'h00;
  localparam logic [2:0] TRIM_IDLE = 3'h0;
  localparam logic [2:0] TRIM_READ = 3'h1;
  localparam logic [2:0] TRIM_ERASE = 3'h2;
  localparam logic [2:0] TRIM_PROG = 3'h3;
  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [7:0] TIMER_RST = 8'h10;
  localparam logic [6:0] COM_END_RST = 7'h43;
  localparam logic [6:0] MUX_HALVE_AT = 7'h3A;
  localparam logic [6:0] MUX_FRAME_MIN = 7'h1C;
  localparam logic [1:0] BIAS_RST = 2'h3;
  // Oscillator cycles per line tick for each line rate code
  localparam logic [15:0] LINE_DIV0 = 16'h0100;
  localparam logic [15:0] LINE_DIV1 = 16'h00C0;
  localparam logic [15:0] LINE_DIV2 = 16'h0080;
  localparam logic [15:0] LINE_DIV3 = 16'h0060;
  // One less than the cycles per timer unit during a trim operation
  localparam logic [7:0] TIMER_UNIT = 8'h14;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    NVT_ST_CMD = 2'b00,
    NVT_ST_P1 = 2'b01,
    NVT_ST_P2 = 2'b10
  } nvt_parse_t;
  typedef enum logic [1:0] {
    NVT_OP_IDLE = 2'b00,
    NVT_OP_RUN = 2'b01,
    NVT_OP_DONE = 2'b10
  } nvt_op_t;
endpackage : nvt_pkg

// File: rtl/nvt_divider.sv
// Purpose: Programmable divider giving a one-cycle enable pulse
// Assumes: Period of at least two cycles
// Notes: A new period applies at once to the running count
`timescale 1ns/10ps
module nvt_divider
  import nvt_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic [15:0] period,
  // Pulse out
  output logic tick
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic wrap;
  assign wrap = (cnt_q >= (period - 16'h0001));
  assign cnt_d = wrap ? 16'h0000 : cnt_q + 16'h0001;
  always_ff @(posedge ref_clk)
  begin
    if (reset || !run)
    begin
      cnt_q <= 16'h0000;
      tick <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick <= wrap;
    end
  end
endmodule : nvt_divider

// File: rtl/nvt_trim_cell.sv
// Purpose: Nonvolatile trim memory model, one word of offset and identity bits
// Assumes: Erase clears all bits, program only sets masked bits
// Notes: Contents survive the logic reset, as a real array would
`timescale 1ns/10ps
module nvt_trim_cell
  import nvt_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Operation strobes
  input wire logic do_erase,
  input wire logic do_prog,
  input wire logic [8:0] prog_mask,
  // Stored value
  output logic [8:0] stored
);
  logic [8:0] cell_q = 9'h000;
  always_ff @(posedge ref_clk)
  begin
    if (do_erase)
      cell_q <= 9'h000;
    else if (do_prog)
      cell_q <= cell_q | prog_mask;
  end
  assign stored = cell_q;
endmodule : nvt_trim_cell

// File: rtl/nvt_ctrl.sv
// Purpose: Trim memory control and LCD drive setting registers
// Assumes: One command or parameter byte per cmd_valid pulse
// Notes: Timing derives from ref_clk, the on-chip oscillator
`timescale 1ns/10ps
module nvt_ctrl
  import nvt_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Host command stream
  input wire logic cmd_valid,
  input wire logic cmd_is_data,
  input wire logic [7:0] cmd_byte,
  // Trim status
  output logic [5:0] trim_control,
  output logic trim_busy,
  output logic [6:0] contrast_offset_bits,
  output logic [1:0] module_ident_bits,
  output logic trim_value_used,
  // Drive settings
  output logic driver_enable_flag,
  output logic [1:0] bias_ratio_code,
  output logic [3:0] bias_ratio_value,
  output logic [1:0] temp_coeff_code,
  output logic [4:0] temp_coeff_hundredths,
  output logic [1:0] drive_voltage_source_sel,
  output logic charge_pump_on,
  output logic [7:0] active_pot,
  output logic [7:0] trim_write_timer,
  output logic [7:0] trim_read_timer,
  // Timing
  output logic [6:0] mux_rate,
  output logic line_tick,
  output logic frame_tick
);
  // ****************************************
  // Registers
  // ****************************************
  nvt_parse_t parse_q;
  nvt_op_t opst_q;
  logic drv_q, fix_inc_q;
  logic [1:0] id_mask_q, br_q, tc_q, pc_q, pdm_q, lrs_q;
  logic [5:0] tctl_q;
  logic [6:0] off_mask_q, cen_q, dst_q, den_q, flt_q, flb_q, mux_q, line_cnt_q;
  logic [7:0] op_q, pot_low_q, pot_high_q, wtim_q, rtim_q, tmr_q, unit_q;
  logic [8:0] read_q;
  wire [8:0] cell_val;
  // ****************************************
  // Command decode
  // ****************************************
  wire is_cmd = cmd_valid && !cmd_is_data;
  wire is_dat = cmd_valid && cmd_is_data;
  wire trim_en = tctl_q[TC_EN_BIT];
  wire op_run = (opst_q != NVT_OP_IDLE);
  wire hit_ctrl = (cmd_byte == OP_TRIM_CTRL);
  wire hit_mask = (cmd_byte == OP_TRIM_MASK);
  wire hit_br = ((cmd_byte & OP_BIAS_MASK) == OP_BIAS_VAL);
  wire hit_tc = ((cmd_byte & OP_TC_MASK) == OP_TC_VAL);
  wire hit_pc = ((cmd_byte & OP_PWR_MASK) == OP_PWR_VAL);
  wire hit_drv = ((cmd_byte & OP_DRV_MASK) == OP_DRV_VAL);
  wire hit_lc = ((cmd_byte & OP_LC_MASK) == OP_LC_VAL);
  wire hit_2b = hit_ctrl || ((cmd_byte & 8'hFC) == OP_POT_LOW) || (cmd_byte == OP_COM_END)
             || (cmd_byte == OP_PART_START) || (cmd_byte == OP_PART_END)
             || (cmd_byte == OP_FIX_TOP) || (cmd_byte == OP_FIX_BOT);
  // Shared 0xF4..0xF7 opcodes are trim commands only while trim is enabled
  wire trim_gate = trim_en && !drv_q;
  wire p1 = is_dat && (parse_q == NVT_ST_P1);
  wire p2 = is_dat && (parse_q == NVT_ST_P2);
  wire ld_mask1 = p1 && (op_q == OP_TRIM_MASK) && trim_gate;
  wire ld_mask2 = p2 && (op_q == OP_TRIM_MASK) && trim_gate;
  wire ld_potl = p1 && (op_q == OP_POT_LOW) && trim_gate;
  wire ld_poth = p1 && (op_q == OP_POT_HIGH) && trim_gate;
  wire ld_wtim = p1 && (op_q == OP_WR_TIMER) && trim_gate;
  wire ld_rtim = p1 && (op_q == OP_RD_TIMER) && trim_gate;
  wire ld_ctrl = p1 && (op_q == OP_TRIM_CTRL);
  wire [2:0] new_cmd = cmd_byte[TC_CMD_LSB +: 3];
  wire new_en = cmd_byte[TC_EN_BIT] && !drv_q;
  wire start_op = ld_ctrl && new_en && !new_cmd[2] && (new_cmd != TRIM_IDLE) && !op_run;
  wire drv_set = is_cmd && hit_drv && (!cmd_byte[0] || (!trim_en && !op_run));
  wire op_done = (opst_q == NVT_OP_RUN) && (tmr_q == 8'h00) && (unit_q == 8'h00);
  wire [2:0] run_cmd = tctl_q[TC_CMD_LSB +: 3];
  // ****************************************
  // Parser and trim control
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      parse_q <= NVT_ST_CMD;
      op_q <= 8'h00;
    end
    else if (is_cmd)
    begin
      parse_q <= hit_2b || hit_mask ? NVT_ST_P1 : NVT_ST_CMD;
      op_q <= cmd_byte;
    end
    else if (is_dat)
      parse_q <= (p1 && op_q == OP_TRIM_MASK) ? NVT_ST_P2 : NVT_ST_CMD;
  end
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      tctl_q <= TRIM_CTRL_RST;
    else if (op_done)
      tctl_q <= {tctl_q[5:4], 1'b0, TRIM_IDLE};
    else if (ld_ctrl && !op_run)
      tctl_q <= {cmd_byte[TC_TEST_BIT], cmd_byte[TC_VALID_BIT], new_en, new_cmd};
  end
  // ****************************************
  // Trim parameter registers
  // ****************************************
  // trim loads ignored when disabled; row registers always load
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      off_mask_q <= 7'h00;
      id_mask_q <= 2'h0;
      pot_low_q <= 8'h00;
      pot_high_q <= 8'h00;
      wtim_q <= TIMER_RST;
      rtim_q <= TIMER_RST;
      read_q <= 9'h000;
      cen_q <= COM_END_RST;
      dst_q <= 7'h00;
      den_q <= COM_END_RST;
      flt_q <= 7'h00;
      flb_q <= 7'h00;
    end
    else
    begin
      if (ld_mask1)
        off_mask_q <= cmd_byte[6:0];
      if (ld_mask2)
        id_mask_q <= cmd_byte[1:0];
      if (ld_potl)
        pot_low_q <= cmd_byte;
      if (ld_poth)
        pot_high_q <= cmd_byte;
      if (ld_wtim)
        wtim_q <= cmd_byte;
      if (ld_rtim)
        rtim_q <= cmd_byte;
      if (op_done && (run_cmd == TRIM_READ))
        read_q <= cell_val;
      if (p1 && (op_q == OP_COM_END))
        cen_q <= cmd_byte[6:0];
      if (p1 && (op_q == OP_PART_START))
        dst_q <= cmd_byte[6:0];
      if (p1 && (op_q == OP_PART_END))
        den_q <= cmd_byte[6:0];
      if (p1 && (op_q == OP_FIX_TOP))
        flt_q <= cmd_byte[6:0];
      if (p1 && (op_q == OP_FIX_BOT))
        flb_q <= cmd_byte[6:0];
    end
  end
  // ****************************************
  // Trim operation sequencer
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      opst_q <= NVT_OP_IDLE;
      tmr_q <= 8'h00;
      unit_q <= 8'h00;
    end
    else
    begin
      case (opst_q)
        NVT_OP_IDLE:
          if (start_op)
          begin
            opst_q <= NVT_OP_RUN;
            tmr_q <= (new_cmd == TRIM_READ) ? rtim_q : wtim_q;
            unit_q <= TIMER_UNIT;
          end
        NVT_OP_RUN:
          if (op_done)
            opst_q <= NVT_OP_DONE;
          else if (unit_q == 8'h00)
          begin
            unit_q <= TIMER_UNIT;
            tmr_q <= tmr_q - 8'h01;
          end
          else
            unit_q <= unit_q - 8'h01;
        NVT_OP_DONE:
          opst_q <= NVT_OP_IDLE;
        default:
          opst_q <= NVT_OP_IDLE;
      endcase
    end
  end
  wire do_erase = op_done && (run_cmd == TRIM_ERASE);
  wire do_prog = op_done && (run_cmd == TRIM_PROG);
  nvt_trim_cell u_cell (
    .ref_clk(ref_clk),
    .do_erase(do_erase),
    .do_prog(do_prog),
    .prog_mask({id_mask_q, off_mask_q}),
    .stored(cell_val)
  );
  // ****************************************
  // Drive setting registers
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      drv_q <= 1'b0;
      br_q <= BIAS_RST;
      tc_q <= 2'h0;
      pc_q <= 2'h0;
      pdm_q <= 2'h0;
      fix_inc_q <= 1'b0;
      lrs_q <= 2'h0;
    end
    else if (is_cmd)
    begin
      if (drv_set)
        drv_q <= cmd_byte[0];
      if (hit_br)
        br_q <= cmd_byte[1:0];
      if (hit_tc)
        tc_q <= cmd_byte[1:0];
      if (hit_pc)
        pc_q <= cmd_byte[3:2];
      // Low nibble: partial mode, fixed include, and line rate packed together
      if (hit_lc)
      begin
        pdm_q <= cmd_byte[3:2];
        lrs_q <= cmd_byte[1:0];
        fix_inc_q <= cmd_byte[3];
      end
    end
  end
  // ****************************************
  // Mux rate, line and frame timing
  // ****************************************
  // mux from row registers
  wire [7:0] span = {1'b0, den_q} - {1'b0, dst_q};
  wire [7:0] fixed = fix_inc_q ? ({1'b0, flt_q} + {1'b0, flb_q}) << 1 : 8'h00;
  wire [7:0] narrow = span + fixed;
  wire [6:0] mux_d = (pdm_q == 2'b11) ? narrow[6:0] : cen_q + 7'h01;
  wire [15:0] base_div = (lrs_q == 2'h0) ? LINE_DIV0 : (lrs_q == 2'h1) ? LINE_DIV1
                       : (lrs_q == 2'h2) ? LINE_DIV2 : LINE_DIV3;
  // halve line rate at low mux
  wire [15:0] line_div = (mux_q <= MUX_HALVE_AT) ? {base_div[14:0], 1'b0} : base_div;
  wire line_en;
  nvt_divider u_line (
    .ref_clk(ref_clk),
    .reset(reset),
    .run(1'b1),
    .period(line_div),
    .tick(line_en)
  );
  wire frame_wrap = line_en && (line_cnt_q >= mux_q - 7'h01);
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      mux_q <= COM_END_RST + 7'h01;
      line_cnt_q <= 7'h00;
      line_tick <= 1'b0;
      frame_tick <= 1'b0;
    end
    else
    begin
      mux_q <= mux_d;
      line_tick <= line_en;
      frame_tick <= frame_wrap && (mux_q > MUX_FRAME_MIN);
      if (frame_wrap)
        line_cnt_q <= 7'h00;
      else if (line_en)
        line_cnt_q <= line_cnt_q + 7'h01;
    end
  end
  // ****************************************
  // Registered outputs
  // ****************************************
  // stored trim only when valid
  wire use_trim = tctl_q[TC_VALID_BIT];
  wire [3:0] br_val = (br_q == 2'h0) ? 4'h5 : 4'h6 + {2'b00, br_q};
  wire [4:0] tc_val = {1'b0, tc_q, 2'b00} + {3'b000, tc_q} + 5'h05;
  wire [7:0] pot_sel = (br_q == 2'h0) ? pot_low_q : (br_q == 2'h3) ? pot_high_q : 8'h00;
  wire [7:0] pot_d = (trim_en && (br_q == 2'h0 || br_q == 2'h3)) ? pot_sel
                   : (use_trim ? {1'b0, read_q[6:0]} : 8'h00);
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      trim_control <= TRIM_CTRL_RST;
      trim_busy <= 1'b0;
      contrast_offset_bits <= 7'h00;
      module_ident_bits <= 2'h0;
      trim_value_used <= 1'b0;
      driver_enable_flag <= 1'b0;
      bias_ratio_code <= BIAS_RST;
      bias_ratio_value <= 4'h9;
      temp_coeff_code <= 2'h0;
      temp_coeff_hundredths <= 5'h05;
      drive_voltage_source_sel <= 2'h0;
      charge_pump_on <= 1'b0;
      active_pot <= 8'h00;
      trim_write_timer <= TIMER_RST;
      trim_read_timer <= TIMER_RST;
      mux_rate <= COM_END_RST + 7'h01;
    end
    else
    begin
      trim_control <= tctl_q;
      trim_busy <= op_run;
      contrast_offset_bits <= use_trim ? read_q[6:0] : 7'h00;
      module_ident_bits <= use_trim ? read_q[8:7] : 2'h0;
      trim_value_used <= use_trim;
      driver_enable_flag <= drv_q;
      bias_ratio_code <= br_q;
      bias_ratio_value <= br_val;
      temp_coeff_code <= tc_q;
      temp_coeff_hundredths <= tc_val;
      drive_voltage_source_sel <= pc_q;
      charge_pump_on <= (pc_q != 2'h0);
      active_pot <= pot_d;
      trim_write_timer <= wtim_q;
      trim_read_timer <= rtim_q;
      mux_rate <= mux_q;
    end
  end
endmodule : nvt_ctrl

// File: bench/nvt_ctrl_sva.sv
// Purpose: Port checks for nvt_ctrl
// Assumes: Outputs settle within three edges after a byte
// Notes: Bound to every nvt_ctrl instance
`timescale 1ns/10ps
module nvt_ctrl_chk
  import nvt_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Trim status
  input wire logic [5:0] trim_control,
  input wire logic trim_busy,
  input wire logic [6:0] contrast_offset_bits,
  input wire logic [1:0] module_ident_bits,
  input wire logic trim_value_used,
  // Drive settings
  input wire logic driver_enable_flag,
  input wire logic [1:0] bias_ratio_code,
  input wire logic [3:0] bias_ratio_value,
  input wire logic [1:0] temp_coeff_code,
  input wire logic [4:0] temp_coeff_hundredths,
  input wire logic [1:0] drive_voltage_source_sel,
  input wire logic charge_pump_on,
  // Timing
  input wire logic [6:0] mux_rate,
  input wire logic frame_tick
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  sequence s_op_start;
    $rose(trim_busy);
  endsequence
  sequence s_op_end;
    $fell(trim_busy);
  endsequence
  chk_mutual_excl: assert property (!(driver_enable_flag && trim_control[3]))
    else $error("driver and trim enable both on");
  chk_enable_clears: assert property (s_op_end |-> ##[0:3] trim_control[3:0] == 4'h0)
    else $error("trim enable not cleared after op");
  chk_reserved_idle: assert property (s_op_start |-> trim_control[2] == 1'b0)
    else $error("trim op started on reserved code");
  chk_start_needs_en: assert property (s_op_start |-> trim_control[3])
    else $error("trim op started without enable");
  chk_valid_gate: assert property (!trim_value_used |->
    contrast_offset_bits == 7'h00 && module_ident_bits == 2'h0)
    else $error("trim value shown while not valid");
  chk_drv_refused: assert property ($rose(driver_enable_flag) |-> !$past(trim_busy))
    else $error("driver enabled during trim op");
  chk_bias_map: assert property (bias_ratio_value ==
    ((bias_ratio_code == 2'h0) ? 4'h5 : 4'h6 + bias_ratio_code))
    else $error("bias ratio value wrong");
  chk_tc_map: assert property (temp_coeff_hundredths ==
    5'h5 * (temp_coeff_code + 5'h1))
    else $error("temperature coefficient wrong");
  chk_pump_sel: assert property (charge_pump_on == (drive_voltage_source_sel != 2'h0))
    else $error("charge pump select wrong");
  chk_frame_gate: assert property (frame_tick |-> mux_rate > MUX_FRAME_MIN)
    else $error("frame tick at low mux rate");
endmodule : nvt_ctrl_chk
bind nvt_ctrl nvt_ctrl_chk u_chk (.ref_clk, .reset, .trim_control, .trim_busy,
  .contrast_offset_bits, .module_ident_bits, .trim_value_used, .driver_enable_flag,
  .bias_ratio_code, .bias_ratio_value, .temp_coeff_code, .temp_coeff_hundredths,
  .drive_voltage_source_sel, .charge_pump_on, .mux_rate, .frame_tick);

// File: bench/nvt_host_model.sv
// Purpose: Host processor sending command and parameter bytes
// Assumes: One byte per cmd_valid pulse, driven after a rising edge
// Notes: Idle byte lines show the inverse of the byte passed to send, before any bit 5 clearing
`timescale 1ns/10ps
module nvt_host_model
  import nvt_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Command stream
  output logic cmd_valid,
  output logic cmd_is_data,
  output logic [7:0] cmd_byte
);
  logic ctrl_next;
  initial
  begin
    cmd_valid = 1'b0;
    cmd_is_data = 1'b0;
    cmd_byte = 8'h00;
    ctrl_next = 1'b0;
  end
  task automatic send(input logic d, input logic [7:0] b);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_is_data <= d;
    cmd_byte <= (d && ctrl_next) ? (b & 8'hDF) : b;
    ctrl_next = !d && (b == OP_TRIM_CTRL);
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    cmd_byte <= ~b;
  endtask : send
endmodule : nvt_host_model

// File: bench/tb_nvt_ctrl.sv
// Purpose: Self-checking bench for nvt_ctrl
// Assumes: Host model drives the command stream
// Notes: Trim cell is erased before any program check
`timescale 1ns/10ps
module tb_nvt_ctrl
  import nvt_pkg::*;
;
  logic ref_clk, reset, cmd_valid, cmd_is_data, trim_busy, trim_value_used;
  logic driver_enable_flag, charge_pump_on, line_tick, frame_tick;
  logic [7:0] cmd_byte, active_pot, trim_write_timer, trim_read_timer;
  logic [5:0] trim_control;
  logic [6:0] contrast_offset_bits, mux_rate;
  logic [1:0] module_ident_bits, bias_ratio_code, temp_coeff_code, drive_voltage_source_sel;
  logic [3:0] bias_ratio_value;
  logic [4:0] temp_coeff_hundredths;
  logic [15:0] divs [4];
  int fail_count, total_checks, g;
  nvt_host_model host (.ref_clk(ref_clk), .cmd_valid(cmd_valid),
    .cmd_is_data(cmd_is_data), .cmd_byte(cmd_byte));
  nvt_ctrl dut (.ref_clk(ref_clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_is_data(cmd_is_data), .cmd_byte(cmd_byte), .trim_control(trim_control),
    .trim_busy(trim_busy), .contrast_offset_bits(contrast_offset_bits),
    .module_ident_bits(module_ident_bits), .trim_value_used(trim_value_used),
    .driver_enable_flag(driver_enable_flag), .bias_ratio_code(bias_ratio_code),
    .bias_ratio_value(bias_ratio_value), .temp_coeff_code(temp_coeff_code),
    .temp_coeff_hundredths(temp_coeff_hundredths),
    .drive_voltage_source_sel(drive_voltage_source_sel), .charge_pump_on(charge_pump_on),
    .active_pot(active_pot), .trim_write_timer(trim_write_timer),
    .trim_read_timer(trim_read_timer), .mux_rate(mux_rate), .line_tick(line_tick),
    .frame_tick(frame_tick));
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ****
  // Tasks
  // ****
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] v);
    total_checks++;
    if (e !== v)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, v);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] op);
    host.send(1'b0, op);
  endtask : cmd
  task automatic cmd2(input logic [7:0] op, input logic [7:0] p);
    host.send(1'b0, op);
    host.send(1'b1, p);
  endtask : cmd2
  task automatic settle;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : settle
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (6) @(negedge ref_clk);
    while (trim_busy !== 1'b0 && n < 5000)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 5000)
    begin
      fail_count++;
      $display("BAD trim_busy expected 0 seen 1");
      test_done;
    end
    settle;
  endtask : wait_idle
  // Cycles between two ticks of the line (fr=0) or frame (fr=1) pulse
  task automatic gap(input logic fr, output int c);
    int n;
    n = 0;
    c = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while ((fr ? frame_tick : line_tick) !== 1'b1 && n < 20000);
    do
    begin
      @(negedge ref_clk);
      c++;
    end
    while ((fr ? frame_tick : line_tick) !== 1'b1 && c < 20000);
    if (n >= 20000 || c >= 20000)
    begin
      fail_count++;
      $display("BAD tick_gap expected tick seen none");
      test_done;
    end
  endtask : gap
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // ****
  // Sequence
  // ****
  initial
  begin
    fail_count = 0;
    total_checks = 0;
    divs = '{LINE_DIV0, LINE_DIV1, LINE_DIV2, LINE_DIV3};
    reset = 1'b1;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    settle;
    chk("trim_control", TRIM_CTRL_RST, trim_control);
    chk("bias_value", 16'h9, bias_ratio_value);
    chk("wr_timer", TIMER_RST, trim_write_timer);
    chk("mux_rate", COM_END_RST + 7'h1, mux_rate);
    cmd2(OP_WR_TIMER, 8'h33);
    settle;
    chk("wr_timer", TIMER_RST, trim_write_timer);
    $display("test reset and refusal done");
    cmd2(OP_TRIM_CTRL, 8'h09);
    cmd2(OP_WR_TIMER, 8'h22);
    cmd2(OP_POT_LOW, 8'h5A);
    cmd(OP_BIAS_VAL);
    settle;
    chk("active_pot", 16'h5A, active_pot);
    cmd2(OP_POT_HIGH, 8'hA5);
    cmd(OP_BIAS_VAL | 8'h03);
    settle;
    chk("active_pot", 16'hA5, active_pot);
    cmd2(OP_TRIM_MASK, 8'h55);
    host.send(1'b1, 8'h02);
    cmd(OP_DRV_VAL | 8'h01);
    settle;
    chk("trim_busy", 16'h1, trim_busy);
    chk("driver_en", 16'h0, driver_enable_flag);
    wait_idle;
    chk("trim_ctrl", 16'h0, trim_control[3:0]);
    chk("wr_timer", 16'h22, trim_write_timer);
    $display("test trim params done");
    cmd2(OP_TRIM_CTRL, 8'h0A);
    wait_idle;
    cmd2(OP_TRIM_CTRL, 8'h0B);
    wait_idle;
    cmd2(OP_TRIM_CTRL, 8'h19);
    cmd2(OP_TRIM_MASK, 8'h2A);
    host.send(1'b1, 8'h01);
    wait_idle;
    chk("offset", 16'h55, contrast_offset_bits);
    chk("ident", 16'h2, module_ident_bits);
    chk("used", 16'h1, trim_value_used);
    cmd2(OP_TRIM_CTRL, 8'h1B);
    wait_idle;
    cmd2(OP_TRIM_CTRL, 8'h19);
    wait_idle;
    chk("offset", 16'h7F, contrast_offset_bits);
    chk("ident", 16'h3, module_ident_bits);
    cmd2(OP_TRIM_CTRL, 8'h09);
    wait_idle;
    chk("offset", 16'h00, contrast_offset_bits);
    chk("used", 16'h0, trim_value_used);
    $display("test program done");
    cmd2(OP_TRIM_CTRL, 8'h0C);
    repeat (8) @(negedge ref_clk);
    chk("trim_busy", 16'h0, trim_busy);
    cmd2(OP_TRIM_CTRL, 8'h00);
    cmd(OP_DRV_VAL | 8'h01);
    settle;
    chk("driver_en", 16'h1, driver_enable_flag);
    cmd2(OP_TRIM_CTRL, 8'h09);
    cmd2(OP_WR_TIMER, 8'h44);
    settle;
    chk("trim_en", 16'h0, trim_control[3]);
    chk("trim_busy", 16'h0, trim_busy);
    chk("wr_timer", 16'h22, trim_write_timer);
    cmd(OP_DRV_VAL);
    $display("test exclusion done");
    for (int i = 0; i < 4; i++)
    begin
      cmd(OP_BIAS_VAL | 8'(i));
      cmd(OP_TC_VAL | 8'(i));
      cmd(OP_PWR_VAL | 8'(i << 2));
      settle;
      chk("bias_value", (i == 0) ? 16'h5 : 16'(i + 6), bias_ratio_value);
      chk("tc", 16'(5 * (i + 1)), temp_coeff_hundredths);
      chk("vsrc", 16'(i), drive_voltage_source_sel);
      chk("pump", 16'(i != 0), charge_pump_on);
    end
    for (int i = 0; i < 4; i++)
    begin
      cmd(OP_LC_VAL | 8'(i));
      gap(1'b0, g);
      gap(1'b0, g);
      chk("line_gap", divs[i], 16'(g));
    end
    gap(1'b1, g);
    gap(1'b1, g);
    chk("frame_gap", (16'(COM_END_RST) + 16'h1) * LINE_DIV3, 16'(g));
    cmd2(OP_COM_END, 8'h39);
    settle;
    chk("mux_rate", 16'(MUX_HALVE_AT), mux_rate);
    gap(1'b0, g);
    gap(1'b0, g);
    chk("line_gap", 16'h2 * LINE_DIV3, 16'(g));
    cmd2(OP_FIX_TOP, 8'h02);
    cmd2(OP_PART_START, 8'h10);
    cmd2(OP_PART_END, 8'h30);
    cmd(OP_LC_VAL | 8'h0F);
    settle;
    chk("mux_rate", 16'h24, mux_rate);
    cmd2(OP_PART_END, 8'h18);
    settle;
    g = 0;
    repeat (3000) @(negedge ref_clk) g += frame_tick;
    chk("low_frames", 16'h0, 16'(g));
    $display("test timing done");
    test_done;
  end
endmodule : tb_nvt_ctrl
